// [src/cvf_pkg.sv]
package cvf_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FWD_CTL1 = 8'h20;
  localparam logic [7:0] IDX_MODE_CTL = 8'h21;
  localparam logic [7:0] IDX_FWD_STATUS = 8'h22;
  localparam logic [7:0] IDX_IRQ_STS = 8'h30;
  localparam logic [7:0] IDX_IRQ_EN = 8'h31;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h32;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Field positions
  localparam int CTL1_BLOCK_LSB = 4;
  localparam int CTL2_DUP_BIT = 7;
  localparam int CTL2_SWR_BIT = 6;
  localparam int CTL2_MODE_LSB = 2;
  localparam int CTL2_ROT_BIT = 0;
  localparam int STS_LOSS_BIT = 2;
  localparam int STS_ALIGNED_BIT = 0;
  localparam int IRQ_LOSS_BIT = 0;
  localparam int IRQ_ALIGN_BIT = 1;
  localparam int IRQ_W = 2;
  // Reset values and writable masks
  localparam logic [7:0] CTL1_RST = 8'h30;
  localparam logic [7:0] CTL2_RST = 8'h01;
  localparam logic [7:0] CTL1_WMASK = 8'h30;
  localparam logic [7:0] CTL2_WMASK = 8'hcd;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_BASIC = 2'b01,
    MODE_ILV = 2'b10,
    MODE_CAT = 2'b11
  } cvf_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b10
  } cvf_state_t;
endpackage : cvf_pkg

// [src/cvf_forward_ctrl.sv]
`timescale 1ns/1ps
module cvf_forward_ctrl import cvf_pkg::*; (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive port engines
  input wire logic [1:0] rx_valid,
  output logic [1:0] rx_ready,
  input wire logic [DATA_W-1:0] rx0_data,
  input wire logic [DATA_W-1:0] rx1_data,
  input wire logic [1:0] rx_last,
  input wire logic [1:0] rx_short,
  input wire logic [1:0] rx_fe,
  // Output port 0
  output logic tx0_valid,
  input wire logic tx0_ready,
  output logic [DATA_W-1:0] tx0_data,
  output logic tx0_last,
  output logic tx0_short,
  output logic tx0_src,
  // Output port 1
  output logic tx1_valid,
  input wire logic tx1_ready,
  output logic [DATA_W-1:0] tx1_data,
  output logic tx1_last,
  output logic tx1_short,
  output logic tx1_src,
  // Interrupt
  output logic irq
);

  logic [7:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d;
  logic loss_q, loss_d, aligned_q, aligned_d, frame_ok_q, frame_ok_d;
  logic [IRQ_W-1:0] ists_q, ists_d, ien_q, ien_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic setup, wr_acc, rd_acc, mapped, loss_evt, align_evt;
  logic hit_c1, hit_c2, hit_st, hit_is, hit_ie, hit_ic;
  logic [7:0] sts_view;
  cvf_mode_t mode;
  logic rot, swr, dup;
  logic [1:0] en, avail, long_av;

  assign mode = cvf_mode_t'(ctl2_q[CTL2_MODE_LSB +: 2]);
  assign rot = ctl2_q[CTL2_ROT_BIT];
  assign swr = ctl2_q[CTL2_SWR_BIT];
  assign dup = ctl2_q[CTL2_DUP_BIT];
  assign en = ~ctl1_q[CTL1_BLOCK_LSB +: 2];
  assign avail = rx_valid & en;
  assign long_av = avail & ~rx_short;

  // Address decode; only aligned word addresses hit
  // Address passed in so each decode re-evaluates when it moves
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction : hit

  assign hit_c1 = hit(paddr, IDX_FWD_CTL1);
  assign hit_c2 = hit(paddr, IDX_MODE_CTL);
  assign hit_st = hit(paddr, IDX_FWD_STATUS);
  assign hit_is = hit(paddr, IDX_IRQ_STS);
  assign hit_ie = hit(paddr, IDX_IRQ_EN);
  assign hit_ic = hit(paddr, IDX_IRQ_CLR);
  assign mapped = hit_c1 | hit_c2 | hit_st | hit_is | hit_ie | hit_ic;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;
  assign irq = |(ists_q & ien_q);

  always_comb begin
    sts_view = 8'h00;
    sts_view[STS_LOSS_BIT] = loss_q;
    sts_view[STS_ALIGNED_BIT] = aligned_q & (mode != MODE_OFF) & ~rot;
  end

  // Register group
  always_comb begin
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    ien_d = ien_q;
    ists_d = ists_q;
    loss_d = loss_q;
    prdata_d = prdata_q;
    // Read data is caught in the setup cycle so prdata leaves a flop
    if (setup) begin
      prdata_d = '0;
      if (hit_c1) prdata_d[7:0] = ctl1_q;
      if (hit_c2) prdata_d[7:0] = ctl2_q;
      if (hit_st) prdata_d[7:0] = sts_view;
      if (hit_is) prdata_d[IRQ_W-1:0] = ists_q;
      if (hit_ie) prdata_d[IRQ_W-1:0] = ien_q;
    end
    if (wr_acc && hit_c1) ctl1_d = pwdata[7:0] & CTL1_WMASK;
    if (wr_acc && hit_c2) ctl2_d = pwdata[7:0] & CTL2_WMASK;
    if (wr_acc && hit_ie) ien_d = pwdata[IRQ_W-1:0];
    if (wr_acc && hit_ic) ists_d = ists_q & ~pwdata[IRQ_W-1:0];
    // Only a loss that was actually returned is cleared
    if (rd_acc && hit_st && prdata_q[STS_LOSS_BIT]) loss_d = 1'b0;
    if (loss_evt) loss_d = 1'b1;
    ists_d[IRQ_LOSS_BIT] = ists_d[IRQ_LOSS_BIT] | loss_evt;
    ists_d[IRQ_ALIGN_BIT] = ists_d[IRQ_ALIGN_BIT] | align_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_q <= CTL1_RST;
      ctl2_q <= CTL2_RST;
      ien_q <= '0;
      ists_q <= '0;
      loss_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      ien_q <= ien_d;
      ists_q <= ists_d;
      loss_q <= loss_d;
      prdata_q <= prdata_d;
    end
  end

  // Forwarding engine
  cvf_state_t state_q, state_d;
  logic cur_q, cur_d, grp_q, grp_d, cat_q, cat_d;
  logic rr_q, rr_d, ilv_q, ilv_d, sel;
  logic out_free, move;
  logic [DATA_W-1:0] cur_data;

  // Both outputs advance together so duplicated data never skews
  assign out_free = (~tx0_valid | tx0_ready) & (~tx1_valid | tx1_ready);
  assign move = (state_q != ST_IDLE) & rx_valid[cur_q] & out_free;
  assign cur_data = cur_q ? rx1_data : rx0_data;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rdy
      assign rx_ready[gi] = (state_q != ST_IDLE) & (cur_q == 1'(gi))
                            & out_free;
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    grp_d = grp_q;
    cat_d = cat_q;
    rr_d = rr_q;
    ilv_d = ilv_q;
    aligned_d = aligned_q;
    frame_ok_d = frame_ok_q;
    loss_evt = 1'b0;
    sel = 1'b0;
    case (state_q)
      ST_IDLE: begin
        grp_d = 1'b0;
        cat_d = 1'b0;
        if (rot) begin
          if (|avail) begin
            sel = avail[rr_q] ? rr_q : ~rr_q;
            state_d = ST_FIRST;
          end
        end else if (mode != MODE_OFF) begin
          if (swr && mode != MODE_CAT && |long_av) begin
            sel = long_av[rr_q] ? rr_q : ~rr_q;
            state_d = ST_FIRST;
          end else if (avail == en && |en) begin
            if (en != 2'b11) begin
              sel = en[1];
              state_d = ST_FIRST;
            end else if (rx_short[0] != rx_short[1]
                         || rx_fe[0] != rx_fe[1]) begin
              // Mismatched heads: drop alignment, flush port 0 alone
              loss_evt = frame_ok_q;
              aligned_d = 1'b0;
              sel = 1'b0;
              state_d = ST_FIRST;
            end else begin
              sel = (mode == MODE_ILV) ? ilv_q : 1'b0;
              if (mode == MODE_ILV) ilv_d = ~ilv_q;
              grp_d = 1'b1;
              cat_d = (mode == MODE_CAT) & ~rx_short[0];
              state_d = ST_FIRST;
            end
            if (state_d == ST_FIRST && !loss_evt
                && rx_short[sel] && rx_fe[sel]) begin
              frame_ok_d = 1'b1;
              aligned_d = 1'b1;
            end
          end
        end else if (|avail) begin
          sel = ~avail[0];
          state_d = ST_FIRST;
        end
        if (state_d == ST_FIRST) begin
          cur_d = sel;
          rr_d = ~sel;
        end
      end
      ST_FIRST: begin
        if (move && rx_last[cur_q]) begin
          if (grp_q) begin
            state_d = ST_SECOND;
            cur_d = ~cur_q;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_SECOND: begin
        if (move && rx_last[cur_q]) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (rot || mode == MODE_OFF) begin
      aligned_d = 1'b0;
      frame_ok_d = 1'b0;
    end
  end

  assign align_evt = aligned_d & ~aligned_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cur_q <= 1'b0;
      grp_q <= 1'b0;
      cat_q <= 1'b0;
      rr_q <= 1'b0;
      ilv_q <= 1'b0;
      aligned_q <= 1'b0;
      frame_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      grp_q <= grp_d;
      cat_q <= cat_d;
      rr_q <= rr_d;
      ilv_q <= ilv_d;
      aligned_q <= aligned_d;
      frame_ok_q <= frame_ok_d;
    end
  end

  // Output stage
  logic v0_d, v1_d, last_d;
  logic [DATA_W-1:0] d0_d, d1_d;
  logic l0_d, l1_d, s0_d, s1_d, p0_d, p1_d;

  // First half of a concatenated pair hides its end marker
  assign last_d = rx_last[cur_q] & ~((state_q == ST_FIRST) & cat_q);

  always_comb begin
    v0_d = tx0_valid;
    v1_d = tx1_valid;
    {d0_d, l0_d, s0_d, p0_d} = {tx0_data, tx0_last, tx0_short, tx0_src};
    {d1_d, l1_d, s1_d, p1_d} = {tx1_data, tx1_last, tx1_short, tx1_src};
    if (out_free) begin
      v0_d = move;
      v1_d = move & dup;
      if (move) begin
        {d0_d, l0_d, s0_d, p0_d} = {cur_data, last_d, rx_short[cur_q], cur_q};
        if (dup) begin
          {d1_d, l1_d, s1_d, p1_d} = {cur_data, last_d, rx_short[cur_q],
                                      cur_q};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx0_valid <= 1'b0;
      tx1_valid <= 1'b0;
      {tx0_data, tx0_last, tx0_short, tx0_src} <= '0;
      {tx1_data, tx1_last, tx1_short, tx1_src} <= '0;
    end else begin
      tx0_valid <= v0_d;
      tx1_valid <= v1_d;
      {tx0_data, tx0_last, tx0_short, tx0_src} <= {d0_d, l0_d, s0_d, p0_d};
      {tx1_data, tx1_last, tx1_short, tx1_src} <= {d1_d, l1_d, s1_d, p1_d};
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dup_data_same: assert property (tx1_valid |-> tx0_valid
    && tx1_data == tx0_data && tx1_last == tx0_last)
    else $error("port 1 differs from port 0");
  a_aligned_wait: assert property ((state_q == ST_IDLE) && !rot
    && mode == MODE_BASIC && !swr && en == 2'b11 && avail != 2'b11
    |=> state_q == ST_IDLE) else $error("line sent before all ports ready");
  a_swr_starts: assert property ((state_q == ST_IDLE) && !rot && swr
    && mode == MODE_BASIC && long_av != 2'b00 |=> state_q == ST_FIRST)
    else $error("ready line not forwarded");
  a_cat_no_split: assert property ((state_q == ST_FIRST) && cat_q
    && move |=> !tx0_last) else $error("concatenated line split");
  a_rot_order: assert property ((state_q == ST_IDLE) && rot
    && avail == 2'b11 |=> cur_q == $past(rr_q))
    else $error("rotation order broken");
  a_loss_after_ok: assert property ($rose(loss_q) |-> $past(frame_ok_q))
    else $error("loss flagged before any aligned frame");
  a_loss_rd_clear: assert property (rd_acc && hit_st
    && prdata_q[STS_LOSS_BIT] && !loss_evt |=> !loss_q)
    else $error("loss flag survived read");
  a_aligned_off: assert property (rot || mode == MODE_OFF
    |=> !aligned_q)
    else $error("aligned flag set while alignment off");
  a_block_port: assert property ((state_q == ST_IDLE) && !en[0]
    |=> state_q == ST_IDLE || cur_q == 1'b1)
    else $error("blocked port forwarded");
  a_rsvd_zero: assert property (setup && hit_c2
    |=> prdata_q[5:4] == 2'b00 && prdata_q[1] == 1'b0)
    else $error("reserved bits not zero");

  c_cat_pair: cover property ((state_q == ST_FIRST) && cat_q
    ##[1:40] state_q == ST_SECOND);
  c_loss: cover property ($rose(loss_q));
  c_dup: cover property (tx1_valid && tx1_ready);
  c_aligned: cover property ($rose(aligned_q));

endmodule : cvf_forward_ctrl

// [testbench/cvf_host_sink.sv]
`timescale 1ns/1ps
module cvf_host_sink import cvf_pkg::*; (
  // Clock, reset and stall control
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  // Output ports
  input wire logic tx0_valid,
  input wire logic [DATA_W-1:0] tx0_data,
  input wire logic tx0_src,
  input wire logic tx0_last,
  output logic tx0_ready,
  input wire logic tx1_valid,
  input wire logic [DATA_W-1:0] tx1_data,
  output logic tx1_ready,
  // Observations
  output int n0,
  output int nl,
  output logic [7:0] srcs,
  output logic [DATA_W-1:0] last0,
  output logic [DATA_W-1:0] last1
);
  logic tick_q;
  // Stalls every other cycle when slow; both ports share one ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= ~tick_q;
    end
  end
  assign tx0_ready = !slow || tick_q;
  assign tx1_ready = tx0_ready;
  // Sampled mid-cycle so the coming edge's handshake is seen settled
  always @(negedge pclk) begin
    if (!presetn) begin
      n0 <= 0;
      nl <= 0;
      srcs <= 8'h00;
    end else if (tx0_valid && tx0_ready) begin
      n0 <= n0 + 1;
      nl <= nl + int'(tx0_last);
      srcs <= {srcs[6:0], tx0_src};
      last0 <= tx0_data;
    end
    if (tx1_valid && tx1_ready) begin
      last1 <= tx1_data;
    end
  end
endmodule : cvf_host_sink

// [testbench/csi_video_forwarding_control_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module csi_video_forwarding_control_tb;
  import cvf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = 0;
  logic [DATA_W-1:0] pwdata = 0, prdata, rx0_data = 0, rx1_data = 0;
  logic [DATA_W-1:0] tx0_data, tx1_data, last0, last1, r;
  logic pready, pslverr, err, irq, slow = 0;
  logic [1:0] rx_valid = 0, rx_ready, rx_last = 0, rx_short = 0, rx_fe = 0;
  logic [1:0] left;
  logic tx0_valid, tx0_ready, tx0_last, tx0_short, tx0_src;
  logic tx1_valid, tx1_ready, tx1_last, tx1_short, tx1_src;
  logic [7:0] srcs;
  int n0, nl, lbase, base, k, mismatches = 0, compares = 0;
  cvf_forward_ctrl cvf_forward_ctrl_i (.*);
  cvf_host_sink cvf_host_sink_i (.*);
  always #5 pclk = ~pclk;
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] e,
                    input string nm);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(nm, e, r)
  endtask : rd
  // Withdraws what is still untaken once lim cycles have passed
  task automatic send(input logic [1:0] v, sh, fe, input logic [31:0] d,
                      input int lim);
    int n;
    logic [1:0] hs;
    @(posedge pclk);
    rx0_data <= d; rx1_data <= ~d; rx_short <= sh; rx_fe <= fe;
    rx_last <= 2'b11; rx_valid <= v;
    left = v; n = 0;
    while (left != 2'b00 && n < lim) begin
      @(negedge pclk);
      hs = left & rx_ready;
      @(posedge pclk);
      left = left & ~hs; n++;
      rx_valid <= (n < lim) ? left : 2'b00;
    end
  endtask : send
  task automatic drain;
    int n;
    n = 0;
    do begin @(negedge pclk); n++; end
    while ((tx0_valid !== 1'b0 || tx1_valid !== 1'b0) && n < 100);
  endtask : drain
  task automatic close_out;
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    mismatches++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(IDX_FWD_CTL1, 32'h30, "ctl1");
    rd(IDX_MODE_CTL, 32'h01, "ctl2");
    rd(IDX_FWD_STATUS, 32'h00, "sts");
    send(2'b11, 2'b00, 2'b00, 32'h1111_0000, 6);
    `CHK("blocked", 2'b11, left)
    wr(IDX_FWD_CTL1, 32'hffff_ffff);
    rd(IDX_FWD_CTL1, 32'h30, "ctl1 rsv");
    wr(IDX_MODE_CTL, 32'hffff_ff3e);
    rd(IDX_MODE_CTL, 32'h0c, "ctl2 rsv");
    rd(8'h7f, 32'h00, "unmapped");
    `CHK("slverr", 1'b1, err)
    wr(IDX_FWD_CTL1, 32'h00);
    wr(IDX_MODE_CTL, 32'h01);
    wr(IDX_IRQ_EN, 32'h01);
    slow <= 1;
    for (k = 0; k < 3; k++) send(2'b11, 2'b11, 2'b11, 32'h2000_0000 + k, 40);
    drain;
    `CHK("rotate a", 1'b1, srcs[0] ^ srcs[1])
    `CHK("rotate b", 1'b1, srcs[1] ^ srcs[2])
    rd(IDX_FWD_STATUS, 32'h00, "sts rot");
    wr(IDX_MODE_CTL, 32'h80);
    send(2'b01, 2'b00, 2'b00, 32'h3333_4444, 40);
    drain;
    `CHK("dup0", 32'h3333_4444, last0)
    `CHK("dup1", 32'h3333_4444, last1)
    base = n0;
    lbase = nl;
    for (k = 1; k < 4; k++) begin
      wr(IDX_MODE_CTL, 32'(k << 2));
      send(2'b01, 2'b00, 2'b00, 32'h4000_0000 + k, 8);
      `CHK("hold", 2'b01, left)
      send(2'b11, 2'b00, 2'b00, 32'h5000_0000 + k, 40);
      `CHK("pair", 2'b00, left)
    end
    drain;
    `CHK("words", base + 6, n0)
    `CHK("line ends", lbase + 5, nl)
    wr(IDX_MODE_CTL, 32'h44);
    send(2'b01, 2'b00, 2'b00, 32'h6000_0000, 8);
    `CHK("swr", 2'b00, left)
    send(2'b01, 2'b01, 2'b01, 32'h6000_0001, 8);
    `CHK("swr short", 2'b01, left)
    wr(IDX_MODE_CTL, 32'h4c);
    send(2'b01, 2'b00, 2'b00, 32'h6000_0002, 8);
    `CHK("swr cat", 2'b01, left)
    wr(IDX_MODE_CTL, 32'h04);
    send(2'b11, 2'b11, 2'b11, 32'h7000_0000, 40);
    drain;
    rd(IDX_FWD_STATUS, 32'h01, "aligned");
    @(negedge pclk);
    `CHK("irq masked", 1'b0, irq)
    send(2'b11, 2'b01, 2'b01, 32'h7000_0001, 20);
    drain;
    `CHK("irq", 1'b1, irq)
    rd(IDX_IRQ_STS, 32'h03, "irq sts");
    rd(IDX_FWD_STATUS, 32'h04, "loss");
    rd(IDX_FWD_STATUS, 32'h00, "loss clr");
    wr(IDX_IRQ_CLR, 32'h03);
    @(negedge pclk);
    `CHK("irq clr", 1'b0, irq)
    send(2'b11, 2'b11, 2'b11, 32'h7000_0002, 40);
    drain;
    wr(IDX_MODE_CTL, 32'h00);
    rd(IDX_FWD_STATUS, 32'h00, "sts off");
    close_out;
  end
endmodule : csi_video_forwarding_control_tb
